//--- verilog/ipr_pkg.sv
// Constants, register map and carrier types of the interrupt pending and priority block.
// Assumes a single system clock shared by the bus, the request sources and the core.
package ipr_pkg;

	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int IDX_W = 12;
	localparam int ADDR_LSB = 2;
	localparam int PERIPH_N = 7;
	localparam int PORT_A_N = 8;
	localparam int PORT_C_N = 4;
	localparam int SRC_N = PERIPH_N + PORT_A_N + PORT_C_N;
	localparam int VEC_W = 5;
	localparam int LVL_W = 2;

	// Register indexes; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PERIPH_PEND = 12'h0fc0;
	localparam logic [IDX_W-1:0] IDX_PERIPH_EN_HI = 12'h0fc1;
	localparam logic [IDX_W-1:0] IDX_PERIPH_EN_LO = 12'h0fc2;
	localparam logic [IDX_W-1:0] IDX_PORT_A_PEND = 12'h0fc3;
	localparam logic [IDX_W-1:0] IDX_PORT_C_PEND = 12'h0fc6;
	localparam logic [IDX_W-1:0] IDX_GLOBAL_CTRL = 12'h0fcf;
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 12'h0fd0;
	localparam logic [IDX_W-1:0] IDX_EVT_MASK = 12'h0fd1;

	// Writable bit masks; reserved bits hold zero
	localparam logic [REG_W-1:0] PERIPH_MASK = 8'h7f;
	localparam logic [REG_W-1:0] PORT_A_MASK = 8'hff;
	localparam logic [REG_W-1:0] PORT_C_MASK = 8'h0f;
	localparam logic [REG_W-1:0] EVT_MASK_BITS = 8'h03;
	localparam int GIE_BIT = 7;
	localparam int EVT_ACK_BIT = 0;
	localparam int EVT_POLL_BIT = 1;

	localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
	localparam logic [VEC_W-1:0] RST_VEC = 5'h00;
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

	// Priority level codes: {enable high, enable low}
	localparam logic [LVL_W-1:0] LVL_OFF = 2'b00;
	localparam logic [LVL_W-1:0] LVL_1 = 2'b01;
	localparam logic [LVL_W-1:0] LVL_2 = 2'b10;
	localparam logic [LVL_W-1:0] LVL_3 = 2'b11;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic valid;
		logic write;
		logic [IDX_W-1:0] index;
	} ipr_dphase_t;

	typedef struct packed {
		logic [PERIPH_N-1:0] periph;
		logic [PORT_A_N-1:0] port_a;
		logic [PORT_C_N-1:0] port_c;
	} ipr_src_t;

	typedef struct packed {
		logic req;
		logic [VEC_W-1:0] vector;
		logic [LVL_W-1:0] level;
	} ipr_core_req_t;

endpackage : ipr_pkg

//--- verilog/ipr_top.sv
// Pending-request, enable-pair and priority logic of the interrupt controller, AHB-Lite slave.
// Assumes request pulses, core strobes and the bus all run on clk; no synchronisers needed.
//
// How it works
// - A source request pulse sets its pending bit in its group register.
// - With global enable set, best pending enabled request goes to the core.
// - Pending bits stay readable when globally disabled, so software can poll them.
// - Peripheral pending register: seven sources in bits 6..0, bit 7 reserved, resets zero.
// - A pending bit reads one while waiting for service, zero otherwise.
// - Port A pending register: bit x for pin x, all eight bits, resets zero.
// - Port C pending register: bits 3..0 for pins, bits 7..4 reserved, resets zero.
// - Enable pair decodes: 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Enable-high register aligns with peripheral pending bits, bit 7 reserved, resets zero.
// - Enable-low register aligns with peripheral pending bits, bit 7 reserved, resets zero.
// - Core acknowledge or a software zero clears a pending bit until next request.
// - Software writing one to a pending bit raises it like a hardware request.
// - Level 3 beats 2 beats 1; same level uses fixed vector table order.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module ipr_top #(
	parameter logic [ipr_pkg::LVL_W-1:0] PIN_LEVEL = ipr_pkg::LVL_1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [ipr_pkg::DATA_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [ipr_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [ipr_pkg::DATA_W-1:0] hrdata,
	output logic hresp,
	input wire logic [ipr_pkg::PERIPH_N-1:0] periph_req,
	input wire logic [ipr_pkg::PORT_A_N-1:0] port_a_req,
	input wire logic [ipr_pkg::PORT_C_N-1:0] port_c_req,
	input wire logic core_ack,
	input wire logic core_enable,
	input wire logic core_disable,
	output logic core_irq,
	output logic [ipr_pkg::VEC_W-1:0] core_vector,
	output logic [ipr_pkg::LVL_W-1:0] core_level,
	output logic irq
);

	ipr_pkg::ipr_dphase_t dphase_reg;
	ipr_pkg::ipr_dphase_t dphase_next;
	logic [ipr_pkg::DATA_W-1:0] hrdata_reg;
	logic [ipr_pkg::DATA_W-1:0] hrdata_next;

	logic [ipr_pkg::REG_W-1:0] periph_pend_reg;
	logic [ipr_pkg::REG_W-1:0] periph_pend_next;
	logic [ipr_pkg::REG_W-1:0] port_a_pend_reg;
	logic [ipr_pkg::REG_W-1:0] port_a_pend_next;
	logic [ipr_pkg::REG_W-1:0] port_c_pend_reg;
	logic [ipr_pkg::REG_W-1:0] port_c_pend_next;
	logic [ipr_pkg::REG_W-1:0] en_hi_reg;
	logic [ipr_pkg::REG_W-1:0] en_hi_next;
	logic [ipr_pkg::REG_W-1:0] en_lo_reg;
	logic [ipr_pkg::REG_W-1:0] en_lo_next;
	logic gie_reg;
	logic gie_next;
	logic [ipr_pkg::REG_W-1:0] evt_status_reg;
	logic [ipr_pkg::REG_W-1:0] evt_status_next;
	logic [ipr_pkg::REG_W-1:0] evt_mask_reg;
	logic [ipr_pkg::REG_W-1:0] evt_mask_next;
	logic irq_reg;
	logic irq_next;

	ipr_pkg::ipr_core_req_t core_reg;
	ipr_pkg::ipr_core_req_t core_next;

	ipr_pkg::ipr_src_t hw_set;
	ipr_pkg::ipr_src_t ack_clr;
	logic [ipr_pkg::SRC_N-1:0] src_pend;
	logic [ipr_pkg::SRC_N-1:0] src_ack;
	logic [ipr_pkg::LVL_W-1:0] src_lvl [ipr_pkg::SRC_N];
	logic addr_take;
	logic wr_en;
	logic [ipr_pkg::REG_W-1:0] wbyte;
	logic ack_take;
	logic best_found;
	logic [ipr_pkg::VEC_W-1:0] best_vec;
	logic [ipr_pkg::LVL_W-1:0] best_lvl;

	assign hw_set.periph = periph_req;
	assign hw_set.port_a = port_a_req;
	assign hw_set.port_c = port_c_req;

	// Zero wait states; every access is OKAY, unmapped reads return zero
	assign addr_take = hsel && hready && (htrans == ipr_pkg::HTRANS_NONSEQ);
	assign wr_en = dphase_reg.valid && dphase_reg.write;
	assign wbyte = hwdata[ipr_pkg::REG_W-1:0];
	assign ack_take = core_ack && core_reg.req;

	always_comb begin
		dphase_next.valid = addr_take;
		dphase_next.write = hwrite;
		dphase_next.index = haddr[ipr_pkg::ADDR_LSB +: ipr_pkg::IDX_W];
	end

	// Vector table order: timer 1 first, port C pin 0 last
	genvar gi;
	generate
		for (gi = 0; gi < ipr_pkg::SRC_N; gi++) begin : g_src
			if (gi < ipr_pkg::PERIPH_N) begin : g_periph
				localparam int B = ipr_pkg::PERIPH_N - 1 - gi;
				assign src_pend[gi] = periph_pend_reg[B];
				assign src_lvl[gi] = {en_hi_reg[B], en_lo_reg[B]};
				assign ack_clr.periph[B] = src_ack[gi];
			end else if (gi < ipr_pkg::PERIPH_N + ipr_pkg::PORT_A_N) begin : g_port_a
				localparam int B = ipr_pkg::PERIPH_N + ipr_pkg::PORT_A_N - 1 - gi;
				assign src_pend[gi] = port_a_pend_reg[B];
				assign src_lvl[gi] = PIN_LEVEL;
				assign ack_clr.port_a[B] = src_ack[gi];
			end else begin : g_port_c
				localparam int B = ipr_pkg::SRC_N - 1 - gi;
				assign src_pend[gi] = port_c_pend_reg[B];
				assign src_lvl[gi] = PIN_LEVEL;
				assign ack_clr.port_c[B] = src_ack[gi];
			end
			assign src_ack[gi] = ack_take && (core_reg.vector == ipr_pkg::VEC_W'(gi));
		end
	endgenerate

	// Later matches overwrite earlier ones: higher level wins, then lower table index
	always_comb begin
		best_found = 1'b0;
		best_vec = ipr_pkg::RST_VEC;
		best_lvl = ipr_pkg::LVL_OFF;
		for (int l = int'(ipr_pkg::LVL_1); l <= int'(ipr_pkg::LVL_3); l++) begin
			for (int s = ipr_pkg::SRC_N - 1; s >= 0; s--) begin
				if (src_pend[s] && (src_lvl[s] == ipr_pkg::LVL_W'(l)) && !src_ack[s]) begin
					best_found = 1'b1;
					best_vec = ipr_pkg::VEC_W'(s);
					best_lvl = ipr_pkg::LVL_W'(l);
				end
			end
		end
	end

	// Pending registers: software write value first, then ack clear, then hardware set wins
	always_comb begin
		periph_pend_next = periph_pend_reg;
		port_a_pend_next = port_a_pend_reg;
		port_c_pend_next = port_c_pend_reg;
		if (wr_en) begin
			unique case (dphase_reg.index)
				ipr_pkg::IDX_PERIPH_PEND: begin
					periph_pend_next = wbyte & ipr_pkg::PERIPH_MASK;
				end
				ipr_pkg::IDX_PORT_A_PEND: begin
					port_a_pend_next = wbyte & ipr_pkg::PORT_A_MASK;
				end
				ipr_pkg::IDX_PORT_C_PEND: begin
					port_c_pend_next = wbyte & ipr_pkg::PORT_C_MASK;
				end
				default: begin
				end
			endcase
		end
		periph_pend_next[ipr_pkg::PERIPH_N-1:0] = periph_pend_next[ipr_pkg::PERIPH_N-1:0] & ~ack_clr.periph;
		port_a_pend_next[ipr_pkg::PORT_A_N-1:0] = port_a_pend_next[ipr_pkg::PORT_A_N-1:0] & ~ack_clr.port_a;
		port_c_pend_next[ipr_pkg::PORT_C_N-1:0] = port_c_pend_next[ipr_pkg::PORT_C_N-1:0] & ~ack_clr.port_c;
		periph_pend_next[ipr_pkg::PERIPH_N-1:0] = periph_pend_next[ipr_pkg::PERIPH_N-1:0] | hw_set.periph;
		port_a_pend_next[ipr_pkg::PORT_A_N-1:0] = port_a_pend_next[ipr_pkg::PORT_A_N-1:0] | hw_set.port_a;
		port_c_pend_next[ipr_pkg::PORT_C_N-1:0] = port_c_pend_next[ipr_pkg::PORT_C_N-1:0] | hw_set.port_c;
	end

	// Enable pairs change only by a write to their own index
	always_comb begin
		en_hi_next = en_hi_reg;
		en_lo_next = en_lo_reg;
		if (wr_en && (dphase_reg.index == ipr_pkg::IDX_PERIPH_EN_HI)) begin
			en_hi_next = wbyte & ipr_pkg::PERIPH_MASK;
		end
		if (wr_en && (dphase_reg.index == ipr_pkg::IDX_PERIPH_EN_LO)) begin
			en_lo_next = wbyte & ipr_pkg::PERIPH_MASK;
		end
	end

	// Global enable: acknowledge and disable strobes beat enable and a written one
	always_comb begin
		gie_next = gie_reg;
		if (wr_en && (dphase_reg.index == ipr_pkg::IDX_GLOBAL_CTRL)) begin
			gie_next = wbyte[ipr_pkg::GIE_BIT];
		end
		if (core_enable) begin
			gie_next = 1'b1;
		end
		if (core_disable || ack_take) begin
			gie_next = 1'b0;
		end
	end

	// Request to the core drops at the edge that ends the acknowledge cycle to avoid a double ack
	always_comb begin
		core_next.req = gie_reg && best_found && !ack_take;
		core_next.vector = best_found ? best_vec : core_reg.vector;
		core_next.level = best_found ? best_lvl : ipr_pkg::LVL_OFF;
	end

	// Event flags: set beats a write-one clear in the same cycle
	always_comb begin
		evt_status_next = evt_status_reg;
		evt_mask_next = evt_mask_reg;
		if (wr_en && (dphase_reg.index == ipr_pkg::IDX_EVT_STATUS)) begin
			evt_status_next = evt_status_reg & ~(wbyte & ipr_pkg::EVT_MASK_BITS);
		end
		if (wr_en && (dphase_reg.index == ipr_pkg::IDX_EVT_MASK)) begin
			evt_mask_next = wbyte & ipr_pkg::EVT_MASK_BITS;
		end
		if (ack_take) begin
			evt_status_next[ipr_pkg::EVT_ACK_BIT] = 1'b1;
		end
		if (!gie_reg && (|hw_set)) begin
			evt_status_next[ipr_pkg::EVT_POLL_BIT] = 1'b1;
		end
		irq_next = |(evt_status_next & evt_mask_next);
	end

	// Read data from next values so a read right after a write sees the new contents
	always_comb begin
		hrdata_next = ipr_pkg::RST_WORD;
		if (addr_take && !hwrite) begin
			unique case (haddr[ipr_pkg::ADDR_LSB +: ipr_pkg::IDX_W])
				ipr_pkg::IDX_PERIPH_PEND: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = periph_pend_next;
				end
				ipr_pkg::IDX_PERIPH_EN_HI: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = en_hi_next;
				end
				ipr_pkg::IDX_PERIPH_EN_LO: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = en_lo_next;
				end
				ipr_pkg::IDX_PORT_A_PEND: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = port_a_pend_next;
				end
				ipr_pkg::IDX_PORT_C_PEND: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = port_c_pend_next;
				end
				ipr_pkg::IDX_GLOBAL_CTRL: begin
					hrdata_next[ipr_pkg::GIE_BIT] = gie_next;
				end
				ipr_pkg::IDX_EVT_STATUS: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = evt_status_next;
				end
				ipr_pkg::IDX_EVT_MASK: begin
					hrdata_next[ipr_pkg::REG_W-1:0] = evt_mask_next;
				end
				default: begin
					hrdata_next = ipr_pkg::RST_WORD;
				end
			endcase
		end
	end

	// Address phase held for the data phase that follows it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dphase_reg <= '0;
		end else begin
			dphase_reg <= dphase_next;
		end
	end

	// Read data stands for one data phase only, zero otherwise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hrdata_reg <= ipr_pkg::RST_WORD;
		end else begin
			hrdata_reg <= hrdata_next;
		end
	end

	// Pending bits: set by sources or software, cleared by acknowledge or software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			periph_pend_reg <= ipr_pkg::RST_BYTE;
			port_a_pend_reg <= ipr_pkg::RST_BYTE;
			port_c_pend_reg <= ipr_pkg::RST_BYTE;
		end else begin
			periph_pend_reg <= periph_pend_next;
			port_a_pend_reg <= port_a_pend_next;
			port_c_pend_reg <= port_c_pend_next;
		end
	end

	// Enable pairs reset to disabled for every peripheral source
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_hi_reg <= ipr_pkg::RST_BYTE;
			en_lo_reg <= ipr_pkg::RST_BYTE;
		end else begin
			en_hi_reg <= en_hi_next;
			en_lo_reg <= en_lo_next;
		end
	end

	// Global enable resets off so nothing is vectored before software is ready
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gie_reg <= 1'b0;
		end else begin
			gie_reg <= gie_next;
		end
	end

	// Registered request keeps vector and level steady while the core samples them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_reg <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	// Event flags and the interrupt line they drive
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evt_status_reg <= ipr_pkg::RST_BYTE;
			evt_mask_reg <= ipr_pkg::RST_BYTE;
			irq_reg <= 1'b0;
		end else begin
			evt_status_reg <= evt_status_next;
			evt_mask_reg <= evt_mask_next;
			irq_reg <= irq_next;
		end
	end

	// Transfer size is not checked; only whole-word accesses are expected
	assign hreadyout = 1'b1;
	assign hresp = ipr_pkg::HRESP_OKAY;
	assign hrdata = hrdata_reg;
	assign core_irq = core_reg.req;
	assign core_vector = core_reg.vector;
	assign core_level = core_reg.level;
	assign irq = irq_reg;

endmodule : ipr_top

//--- testbench/ipr_props.sv
// Port-level assertion checker of the interrupt pending and priority block.
// Assumes one clock domain; bound into every ipr_top instance below.
`timescale 1ns/1ps
module ipr_props #(
	parameter logic [ipr_pkg::LVL_W-1:0] PIN_LEVEL = ipr_pkg::LVL_1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [ipr_pkg::DATA_W-1:0] hrdata,
	input wire logic hresp,
	input wire logic core_ack,
	input wire logic core_enable,
	input wire logic core_disable,
	input wire logic core_irq,
	input wire logic [ipr_pkg::VEC_W-1:0] core_vector,
	input wire logic [ipr_pkg::LVL_W-1:0] core_level,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic rd_take;
	assign rd_take = hsel && hready && htrans == ipr_pkg::HTRANS_NONSEQ && !hwrite;
	ready_okay_a: assert property (hreadyout && hresp == ipr_pkg::HRESP_OKAY) else $error("bus not ready or not okay");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper read bits set");
	rdata_idle_a: assert property (!rd_take |=> hrdata == ipr_pkg::RST_WORD) else $error("read data outside phase");
	ack_clears_a: assert property (core_ack && core_irq |=> !core_irq) else $error("request kept after ack");
	disable_blocks_a: assert property (core_disable ##1 !core_enable |=> !core_irq) else $error("request while disabled");
	level_valid_a: assert property (core_irq |-> core_level != ipr_pkg::LVL_OFF) else $error("disabled level shown");
	vector_range_a: assert property (core_irq |-> core_vector <= 5'h12) else $error("vector out of range");
	pin_level_a: assert property (core_irq && core_vector >= 5'h07 |-> core_level == PIN_LEVEL) else $error("pin level wrong");
	reset_out_a: assert property ($rose(rstn) |-> !core_irq && !irq && hrdata == ipr_pkg::RST_WORD) else $error("outputs not reset");
endmodule : ipr_props

bind ipr_top ipr_props #(.PIN_LEVEL(PIN_LEVEL)) i_props (.clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_ack(core_ack),
	.core_enable(core_enable), .core_disable(core_disable), .core_irq(core_irq), .core_vector(core_vector),
	.core_level(core_level), .irq(irq));

//--- testbench/ipr_core_model.sv
// Behavioural processor core: acknowledges a presented vector after a delay.
// Assumes the bench enables it only where a scenario expects an acknowledge.
`timescale 1ns/1ps
module ipr_core_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic core_irq,
	input wire logic [ipr_pkg::VEC_W-1:0] core_vector,
	input wire logic ack_en,
	input wire logic [3:0] dly,
	output logic core_ack,
	output logic [ipr_pkg::VEC_W-1:0] last_vec
);
	logic [3:0] cnt;
	// Guard on core_ack keeps one acknowledge per presented request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_ack <= 1'b0;
			cnt <= 4'h0;
			last_vec <= 5'h00;
		end else begin
			core_ack <= 1'b0;
			cnt <= 4'h0;
			if (core_irq && ack_en && !core_ack) begin
				if (cnt == dly) begin
					core_ack <= 1'b1;
					last_vec <= core_vector;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule : ipr_core_model

//--- testbench/tb.sv
// Self-checking bench of ipr_top: AHB-Lite tasks, request pulses, core model.
// Assumes a zero-wait slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, core_ack, core_enable, core_disable, core_irq, irq, ack_en;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, core_level;
	logic [2:0] hsize;
	logic [6:0] periph_req;
	logic [7:0] port_a_req;
	logic [3:0] port_c_req, dly;
	logic [4:0] core_vector, last_vec;
	int n_fail = 0;
	int comparisons = 0;
	localparam logic [11:0] IDX [5] = '{ipr_pkg::IDX_PERIPH_PEND, ipr_pkg::IDX_PERIPH_EN_HI,
		ipr_pkg::IDX_PERIPH_EN_LO, ipr_pkg::IDX_PORT_A_PEND, ipr_pkg::IDX_PORT_C_PEND};
	localparam logic [7:0] MSK [5] = '{8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h0f};
	ipr_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.periph_req(periph_req), .port_a_req(port_a_req), .port_c_req(port_c_req), .core_ack(core_ack),
		.core_enable(core_enable), .core_disable(core_disable), .core_irq(core_irq), .core_vector(core_vector),
		.core_level(core_level), .irq(irq));
	ipr_core_model i_core (.clk(clk), .rstn(rstn), .core_irq(core_irq), .core_vector(core_vector),
		.ack_en(ack_en), .dly(dly), .core_ack(core_ack), .last_vec(last_vec));
	task automatic end_of_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// Read data is taken at the edge that ends the data phase
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
		@(posedge clk);
		htrans <= ipr_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {18'h0_0000, idx, 2'b00};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic rdc(input string n, input logic [11:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(n, {24'h00_0000, e}, q)
	endtask : rdc
	task automatic strobe(input logic [6:0] p, input logic [7:0] a, input logic [3:0] c, input logic en, input logic ds);
		@(posedge clk);
		periph_req <= p;
		port_a_req <= a;
		port_c_req <= c;
		core_enable <= en;
		core_disable <= ds;
		@(posedge clk);
		{periph_req, port_a_req, port_c_req, core_enable, core_disable} <= 21'h00_0000;
		repeat (2) @(posedge clk);
	endtask : strobe
	task automatic wait_ack;
		for (int i = 0; i < 40 && core_ack !== 1'b1; i++) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask : wait_ack
	task automatic s_regs;
		for (int i = 0; i < 5; i++) rdc("reset", IDX[i], 8'h00);
		rdc("unmapped", 12'h0fc9, 8'h00);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, IDX[i], MSK[i]);
			rdc("rw", IDX[i], MSK[i]);
			bus(1'b1, IDX[i], 8'h00);
			rdc("clear", IDX[i], 8'h00);
		end
	endtask : s_regs
	task automatic s_poll;
		strobe(7'h7f, 8'ha5, 4'h9, 1'b0, 1'b0);
		rdc("poll0", IDX[0], 8'h7f);
		rdc("poll_a", IDX[3], 8'ha5);
		rdc("poll_c", IDX[4], 8'h09);
		`CHK("no_irq", 1'b0, core_irq)
		for (int i = 0; i < 5; i++) bus(1'b1, IDX[i], 8'h00);
	endtask : s_poll
	task automatic s_level;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, IDX[1], {1'b0, c[1], 6'h00});
			bus(1'b1, IDX[2], {1'b0, c[0], 6'h00});
			bus(1'b1, IDX[0], 8'h40);
			strobe(7'h00, 8'h00, 4'h0, 1'b1, 1'b0);
			`CHK("irq", c != 0, core_irq)
			if (c != 0) `CHK("lvl", 2'(c), core_level)
		end
		bus(1'b1, IDX[1], 8'h11);
		bus(1'b1, IDX[2], 8'h41);
		bus(1'b1, IDX[0], 8'h51);
		repeat (2) @(posedge clk);
		`CHK("best", 7'h1b, {core_vector, core_level})
		ack_en <= 1'b1;
		wait_ack();
		`CHK("acked", 6'h0c, {last_vec, core_irq})
		rdc("after_ack", IDX[0], 8'h50);
		dly <= 4'h3;
		strobe(7'h00, 8'h00, 4'h0, 1'b1, 1'b0);
		wait_ack();
		ack_en <= 1'b0;
		`CHK("second", 5'h02, last_vec)
		strobe(7'h00, 8'h80, 4'h0, 1'b1, 1'b0);
		`CHK("tie", 7'h01, {core_vector, core_level})
		bus(1'b1, IDX[0], 8'h00);
		repeat (2) @(posedge clk);
		`CHK("pin", 7'h1d, {core_vector, core_level})
		strobe(7'h00, 8'h00, 4'h0, 1'b0, 1'b1);
		`CHK("disabled", 1'b0, core_irq)
	endtask : s_level
	// Event status bit 0 records an acknowledge; irq follows status and mask
	task automatic s_irq;
		`CHK("masked", 1'b0, irq)
		bus(1'b0, ipr_pkg::IDX_EVT_STATUS, 8'h00);
		`CHK("evt", 1'b1, q[0])
		bus(1'b1, ipr_pkg::IDX_EVT_MASK, 8'h01);
		repeat (2) @(posedge clk);
		`CHK("irq_on", 1'b1, irq)
		bus(1'b1, ipr_pkg::IDX_EVT_STATUS, 8'h01);
		repeat (2) @(posedge clk);
		`CHK("irq_off", 1'b0, irq)
	endtask : s_irq
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{rstn, hwrite, htrans, haddr, hwdata, ack_en, dly} = '0;
		{periph_req, port_a_req, port_c_req, core_enable, core_disable} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		s_regs();
		s_poll();
		s_level();
		s_irq();
		end_of_test();
	end
endmodule : tb
